// *** bus_matrix_params.svh ***
// Offsets, field positions, reset values and counts of the bus matrix configuration block
`ifndef BUS_MATRIX_PARAMS_SVH
`define BUS_MATRIX_PARAMS_SVH

`define BMC_ADDR_W 12
`define BMC_OFS_CONFIG 12'h000
`define BMC_OFS_INT_STATUS 12'h004
`define BMC_OFS_INT_CLEAR 12'h008
`define BMC_OFS_INT_ENABLE 12'h00C
`define BMC_OFS_STATE 12'h010

`define BMC_NUM_INIT 5
`define BMC_BIT_ERR_CPU_INSTR 16
`define BMC_BIT_ERR_CPU_DATA 17
`define BMC_BIT_ERR_DMA 18
`define BMC_BIT_ERR_DEBUG 19
`define BMC_BIT_ERR_SHARED 20
`define BMC_BIT_WAIT 6
`define BMC_ARB_HI 2
`define BMC_ARB_LO 0

`define BMC_CONFIG_RESET 32'h001F0041
`define BMC_CONFIG_WMASK 32'h001F0047
`define BMC_ARB_MODE0 3'h0
`define BMC_ARB_MODE1 3'h1
`define BMC_ARB_MODE2 3'h2

`define BMC_IDX_CPU_INSTR 0
`define BMC_IDX_CPU_DATA 1

`endif

// *** bus_matrix_pkg.sv ***
// Types shared by the bus matrix configuration modules
package bus_matrix_pkg;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_BUSY = 2'b01
  } arb_state_t;
  typedef logic [4:0] init_vec_t;
endpackage

// *** err_gate_if.sv ***
// Carrier between the configuration block and its bus error gate
`timescale 1ns/10ps
interface err_gate_if;
  logic [4:0] err_en;
  logic [4:0] unmapped;
  logic debug_mode;
  logic [4:0] bus_err;
  modport cfg (output err_en, output unmapped, output debug_mode, input bus_err);
  modport gate (input err_en, input unmapped, input debug_mode, output bus_err);
endinterface

// *** bus_err_gate.sv ***
// Per-initiator bus error gating of unmapped-address accesses
`timescale 1ns/10ps
`include "bus_matrix_params.svh"
module bus_err_gate (
  input wire logic pclk,
  input wire logic presetn,
  err_gate_if.gate eg
);
  logic [4:0] bus_err_r;
  logic [4:0] bus_err_nxt;

  always_comb begin
    bus_err_nxt = eg.unmapped & eg.err_en; // RULE1 RULE2 RULE3
    // CPU ports are exempt while halted in debug
    if (eg.debug_mode) begin
      bus_err_nxt[`BMC_IDX_CPU_INSTR] = 1'b0; // RULE5
      bus_err_nxt[`BMC_IDX_CPU_DATA] = 1'b0; // RULE4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_err_r <= 5'h00;
    end else begin
      bus_err_r <= bus_err_nxt;
    end
  end

  assign eg.bus_err = bus_err_r;
endmodule // bus_err_gate

// *** bus_matrix_config.sv ***
// Bus matrix configuration register, arbiter and bus error events over APB
`timescale 1ns/10ps
`include "bus_matrix_params.svh"

// Summary of operation
// RULE1 - Bit 20 enables shared bus errors
// RULE2 - Bit 19 enables debug unit errors
// RULE3 - Bit 18 enables DMA errors
// RULE4 - Bit 17 CPU data errors, off in debug
// RULE5 - Bit 16 CPU fetch errors, off in debug
// RULE6 - All five error enables reset to one
// RULE7 - Bit 6 adds one RAM wait state
// RULE8 - Bits 2:0 pick mode 0/1/2, default 1
// RULE9 - Software avoids reserved codes 011 to 111
// RULE10 - Unimplemented bits read zero, ignore writes
// RULE11 - New settings apply only to later transactions; the error enables apply from the next access
module bus_matrix_config #(
  parameter int NUM_INIT = `BMC_NUM_INIT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INIT-1:0] req,
  input wire logic txn_done,
  input wire logic [NUM_INIT-1:0] unmapped,
  input wire logic debug_mode,
  output logic [NUM_INIT-1:0] grant,
  output logic ram_wait_state,
  output logic [2:0] arbitration_mode,
  output logic [NUM_INIT-1:0] bus_err,
  output logic irq
);

  // Lowest set bit wins; reused by every arbitration mode
  function automatic bus_matrix_pkg::init_vec_t pick_lowest(input bus_matrix_pkg::init_vec_t r);
    bus_matrix_pkg::init_vec_t g;
    g = 5'h00;
    for (int i = NUM_INIT - 1; i >= 0; i--) begin
      if (r[i]) begin
        g = 5'h00;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  // Mirror lets mode 1 reuse the lowest-first picker
  function automatic bus_matrix_pkg::init_vec_t reverse(input bus_matrix_pkg::init_vec_t v);
    bus_matrix_pkg::init_vec_t o;
    o = 5'h00;
    for (int i = 0; i < NUM_INIT; i++) begin
      o[i] = v[NUM_INIT - 1 - i];
    end
    return o;
  endfunction

  // Rotate right by n so that index n lands at bit 0
  function automatic bus_matrix_pkg::init_vec_t rot_right(input bus_matrix_pkg::init_vec_t v,
                                                          input logic [2:0] n);
    bus_matrix_pkg::init_vec_t o;
    o = 5'h00;
    for (int i = 0; i < NUM_INIT; i++) begin
      o[i] = v[(i + int'(n)) % NUM_INIT];
    end
    return o;
  endfunction

  // Undoes rot_right, winner back in place
  function automatic bus_matrix_pkg::init_vec_t rot_left(input bus_matrix_pkg::init_vec_t v,
                                                         input logic [2:0] n);
    bus_matrix_pkg::init_vec_t o;
    o = 5'h00;
    for (int i = 0; i < NUM_INIT; i++) begin
      o[(i + int'(n)) % NUM_INIT] = v[i];
    end
    return o;
  endfunction

  // One-hot to index for the round-robin memory
  function automatic logic [2:0] vec_index(input bus_matrix_pkg::init_vec_t v);
    logic [2:0] k;
    k = 3'h0;
    for (int i = 0; i < NUM_INIT; i++) begin
      if (v[i]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction

  // Register storage
  logic [31:0] config_r;
  logic [NUM_INIT-1:0] int_status_r;
  logic [NUM_INIT-1:0] int_enable_r;

  // APB answer
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] rdata_nxt;
  logic addr_hit;

  // Arbiter state
  bus_matrix_pkg::arb_state_t state_r;
  bus_matrix_pkg::arb_state_t state_nxt;
  logic [NUM_INIT-1:0] grant_r;
  logic [NUM_INIT-1:0] grant_nxt;
  logic [2:0] last_idx_r;
  logic [2:0] arb_mode_eff_r;
  logic wait_eff_r;
  logic irq_r;

  logic setup_phase;
  logic wr_commit;
  logic [11:0] word_addr;
  logic [31:0] wmask_bytes;
  logic [NUM_INIT-1:0] err_events;

  err_gate_if eg ();

  assign word_addr = paddr[11:0];
  assign setup_phase = psel && !penable;
  // Write lands only at the edge where the access phase is answered
  assign wr_commit = psel && penable && pready_r && pwrite && !pslverr_r;

  // Byte lanes of the write
  always_comb begin
    wmask_bytes = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // Address decode and read mux
  always_comb begin
    addr_hit = 1'b1;
    rdata_nxt = 32'h00000000;
    if (paddr[31:12] != 20'h00000 || paddr[1:0] != 2'h0) begin
      addr_hit = 1'b0;
    end else begin
      case (word_addr)
        `BMC_OFS_CONFIG: begin
          rdata_nxt = config_r & `BMC_CONFIG_WMASK; // RULE10
        end
        `BMC_OFS_INT_STATUS: begin
          rdata_nxt[NUM_INIT-1:0] = int_status_r;
        end
        `BMC_OFS_INT_CLEAR: begin
          // Write-only: reads as zero
          rdata_nxt = 32'h00000000;
        end
        `BMC_OFS_INT_ENABLE: begin
          rdata_nxt[NUM_INIT-1:0] = int_enable_r;
        end
        `BMC_OFS_STATE: begin
          rdata_nxt[2:0] = arb_mode_eff_r;
          rdata_nxt[3] = wait_eff_r;
          rdata_nxt[4] = (state_r == bus_matrix_pkg::ARB_BUSY);
          rdata_nxt[5] = debug_mode;
          rdata_nxt[12:8] = grant_r;
        end
        default: begin
          addr_hit = 1'b0;
        end
      endcase
    end
  end

  // Zero-wait slave: answer prepared in setup, shown for the one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      if (setup_phase) begin
        pready_r <= 1'b1;
        pslverr_r <= !addr_hit;
        prdata_r <= (!pwrite && addr_hit) ? rdata_nxt : 32'h00000000;
      end else begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_r <= `BMC_CONFIG_RESET; // RULE6 RULE7 RULE8
    end else if (wr_commit && word_addr == `BMC_OFS_CONFIG) begin
      // Reserved codes are stored as written; grants then pick the lowest index, as in mode 0
      config_r <= (config_r & ~(wmask_bytes & `BMC_CONFIG_WMASK)) |
                  (pwdata & wmask_bytes & `BMC_CONFIG_WMASK); // RULE10 RULE9
    end
  end

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_r <= 5'h00;
    end else if (wr_commit && word_addr == `BMC_OFS_INT_ENABLE && pstrb[0]) begin
      int_enable_r <= pwdata[NUM_INIT-1:0];
    end
  end

  // Sticky status: a new error beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r <= 5'h00;
    end else begin
      if (wr_commit && word_addr == `BMC_OFS_INT_CLEAR && pstrb[0]) begin
        int_status_r <= (int_status_r & ~pwdata[NUM_INIT-1:0]) | err_events;
      end else begin
        int_status_r <= int_status_r | err_events;
      end
    end
  end

  // Registered level, one clock behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(int_status_r & int_enable_r);
    end
  end

  // Error gate sees the live enables; a changed bit applies from the next access
  assign eg.err_en = {config_r[`BMC_BIT_ERR_SHARED], // RULE1
                      config_r[`BMC_BIT_ERR_DEBUG], // RULE2
                      config_r[`BMC_BIT_ERR_DMA], // RULE3
                      config_r[`BMC_BIT_ERR_CPU_DATA], // RULE4
                      config_r[`BMC_BIT_ERR_CPU_INSTR]}; // RULE5
  assign eg.unmapped = unmapped;
  assign eg.debug_mode = debug_mode;
  assign err_events = eg.bus_err;

  bus_err_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .eg(eg)
  );

  // Grant selection by the mode the transaction will run under
  always_comb begin
    bus_matrix_pkg::init_vec_t rot;
    rot = 5'h00;
    grant_nxt = 5'h00;
    case (config_r[`BMC_ARB_HI:`BMC_ARB_LO])
      `BMC_ARB_MODE0: begin
        grant_nxt = pick_lowest(req); // RULE8
      end
      `BMC_ARB_MODE1: begin
        grant_nxt = reverse(pick_lowest(reverse(req))); // RULE8
      end
      `BMC_ARB_MODE2: begin
        // Round robin: search starts just past the last winner
        rot = rot_right(req, 3'((int'(last_idx_r) + 1) % NUM_INIT));
        grant_nxt = rot_left(pick_lowest(rot), 3'((int'(last_idx_r) + 1) % NUM_INIT)); // RULE8
      end
      default: begin
        grant_nxt = pick_lowest(req);
      end
    endcase
  end

  // Busy from the grant until the done pulse
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bus_matrix_pkg::ARB_IDLE: begin
        if (|req) begin
          state_nxt = bus_matrix_pkg::ARB_BUSY;
        end
      end
      bus_matrix_pkg::ARB_BUSY: begin
        if (txn_done) begin
          state_nxt = bus_matrix_pkg::ARB_IDLE;
        end
      end
      default: begin
        state_nxt = bus_matrix_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= bus_matrix_pkg::ARB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Grant latched at the idle edge, dropped after done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_r <= 5'h00;
    end else if (state_r == bus_matrix_pkg::ARB_IDLE && |req) begin
      grant_r <= grant_nxt;
    end else if (state_r == bus_matrix_pkg::ARB_BUSY && txn_done) begin
      grant_r <= 5'h00;
    end
  end

  // Round-robin memory survives the idle gap between grants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_idx_r <= 3'(NUM_INIT - 1);
    end else if (state_r == bus_matrix_pkg::ARB_IDLE && |req) begin
      last_idx_r <= vec_index(grant_nxt);
    end
  end

  // Settings are frozen for the whole transaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_mode_eff_r <= `BMC_ARB_MODE1;
      wait_eff_r <= 1'b1;
    end else if (state_r == bus_matrix_pkg::ARB_IDLE && |req) begin
      arb_mode_eff_r <= config_r[`BMC_ARB_HI:`BMC_ARB_LO]; // RULE11
      wait_eff_r <= config_r[`BMC_BIT_WAIT]; // RULE7 RULE11
    end
  end

  // Every output straight from a flip-flop
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign grant = grant_r;
  assign ram_wait_state = wait_eff_r;
  assign arbitration_mode = arb_mode_eff_r;
  assign bus_err = eg.bus_err;
  assign irq = irq_r;

endmodule // bus_matrix_config

// *** bus_matrix_config_props.sv ***
// Port checks for the bus matrix configuration block
`timescale 1ns/10ps
`include "bus_matrix_params.svh"
module bus_matrix_config_props #(
  parameter int NUM_INIT = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [NUM_INIT-1:0] unmapped,
  input wire logic debug_mode,
  input wire logic [NUM_INIT-1:0] grant,
  input wire logic ram_wait_state,
  input wire logic [2:0] arbitration_mode,
  input wire logic [NUM_INIT-1:0] bus_err
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  shared_err_a: assert property (bus_err[4] |-> $past(unmapped[4])) else $error("stray shared error");
  debug_err_a: assert property (bus_err[3] |-> $past(unmapped[3])) else $error("stray debug error");
  dma_err_a: assert property (bus_err[2] |-> $past(unmapped[2])) else $error("stray dma error");
  data_debug_a: assert property (debug_mode && unmapped[1] |=> !bus_err[1]) else $error("data error in debug");
  fetch_debug_a: assert property (debug_mode && unmapped[0] |=> !bus_err[0]) else $error("fetch error in debug");
  cfg_unused_a: assert property (pready && !pwrite && paddr == 32'h0 |->
    (prdata & ~`BMC_CONFIG_WMASK) == 32'h0) else $error("unused bits set");
  // Settings frozen while a grant is held
  mode_hold_a: assert property (grant != 0 && $stable(grant) |-> $stable(arbitration_mode)) else $error("mode moved");
  wait_hold_a: assert property (grant != 0 && $stable(grant) |-> $stable(ram_wait_state)) else $error("wait moved");
  reset_out_a: assert property ($rose(presetn) |-> ram_wait_state && arbitration_mode == 3'h1) else $error("reset out");
endmodule // bus_matrix_config_props
bind bus_matrix_config bus_matrix_config_props #(.NUM_INIT(NUM_INIT)) props_i (.pclk, .presetn, .pwrite, .paddr,
  .prdata, .pready, .unmapped, .debug_mode, .grant, .ram_wait_state, .arbitration_mode, .bus_err);

// *** initiator_model.sv ***
// Initiators: raise requests, end each granted transaction
`timescale 1ns/10ps
module initiator_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] want,
  input wire logic slow,
  input wire logic [4:0] grant,
  output logic [4:0] req,
  output logic txn_done
);
  logic [3:0] cnt_r;
  logic fire;
  assign fire = grant != 5'h00 && !txn_done && cnt_r == (slow ? 4'h7 : 4'h1);
  // Request stays up until served, so a slow grant never loses it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 5'h00;
      txn_done <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      txn_done <= fire;
      cnt_r <= (grant != 5'h00 && !txn_done && !fire) ? cnt_r + 4'h1 : 4'h0;
      req <= (req & ~(fire ? grant : 5'h00)) | want;
    end
  end
endmodule // initiator_model

// *** tb_bus_matrix_config.sv ***
// Bench for the bus matrix configuration block
`timescale 1ns/10ps
`include "bus_matrix_params.svh"
module tb_bus_matrix_config;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, debug_mode = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, seed = 32'h0000C79F;
  logic [31:0] prdata;
  logic pready, pslverr, txn_done, irq, ram_wait_state;
  logic [2:0] arbitration_mode;
  logic [4:0] req, grant, bus_err;
  logic [4:0] want = 5'h0, unmapped = 5'h0, unm_q = 5'h0, gprev = 5'h0;
  logic [4:0] first[3] = '{5'h01, 5'h10, 5'h10};
  logic [32:0] rq[$];
  logic [8:0] gq[$];
  logic [4:0] eq[$];
  int num_errors = 0;
  int checks_done = 0;
  always #4 pclk = ~pclk;
  bus_matrix_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .req, .txn_done, .unmapped, .debug_mode, .grant, .ram_wait_state, .arbitration_mode,
    .bus_err, .irq);
  initiator_model ini (.pclk, .presetn, .want, .slow, .grant, .req, .txn_done);
  task automatic end_sim();
    if (rq.size() != 0 || gq.size() != 0 || eq.size() != 0) begin
      num_errors++;
      $display("MISMATCH %0t expected results never seen", $time);
    end
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t no bus answer", $time);
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic hit(input int i, input logic [4:0] e);
    unmapped <= 5'h01 << i;
    eq.push_back(e);
    @(posedge pclk);
    unmapped <= 5'h00;
    @(posedge pclk);
  endtask
  task automatic go(input logic [4:0] w);
    int n;
    want <= w;
    @(posedge pclk);
    want <= 5'h00;
    @(posedge pclk);
    n = 0;
    while ((req !== 5'h0 || grant !== 5'h0) && n < 100) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      $display("MISMATCH %0t transfers never finished", $time);
      end_sim();
    end
  endtask
  // Outputs are read before this edge's updates land
  always @(posedge pclk) begin
    unm_q <= unmapped;
    gprev <= grant;
    if (psel && penable && pready && !pwrite) chk({7'h0, pslverr, prdata}, {7'h0, rq.pop_front()});
    if (unm_q != 5'h0) chk({35'h0, bus_err}, {35'h0, eq.pop_front()});
    if (grant != 5'h0 && gprev == 5'h0) chk({31'h0, ram_wait_state, arbitration_mode, grant}, {31'h0, gq.pop_front()});
  end
  initial begin
    #200000;
    num_errors++;
    $display("MISMATCH %0t run limit reached", $time);
    end_sim();
  end
  initial begin
    int i, c, m;
    logic [31:0] v;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`BMC_OFS_CONFIG, {1'b0, `BMC_CONFIG_RESET});
    rd(`BMC_OFS_STATE, 33'h9);
    wr(`BMC_OFS_CONFIG, 32'hFFE0FFB8);
    rd(`BMC_OFS_CONFIG, 33'h0);
    for (i = 0; i < 4; i++) begin
      v = rnd();
      v[2:0] = 3'(v[2:0] % 3);
      wr(`BMC_OFS_CONFIG, v);
      rd(`BMC_OFS_CONFIG, {1'b0, v & `BMC_CONFIG_WMASK});
    end
    rd(12'h040, 33'h100000000);
    for (c = 0; c < 3; c++) begin
      wr(`BMC_OFS_CONFIG, c == 1 ? 32'h41 : `BMC_CONFIG_RESET);
      debug_mode <= (c == 2);
      for (i = 0; i < 5; i++) hit(i, (c == 1 || (c == 2 && i < 2)) ? 5'h00 : 5'h01 << i);
    end
    rd(`BMC_OFS_INT_STATUS, 33'h1F);
    wr(`BMC_OFS_INT_ENABLE, 32'h4);
    @(posedge pclk);
    chk({39'h0, irq}, 40'h1);
    wr(`BMC_OFS_INT_ENABLE, 32'h0);
    @(posedge pclk);
    chk({39'h0, irq}, 40'h0);
    wr(`BMC_OFS_INT_CLEAR, 32'h1F);
    rd(`BMC_OFS_INT_STATUS, 33'h0);
    slow <= 1'b1;
    for (m = 0; m < 3; m++) begin
      wr(`BMC_OFS_CONFIG, 32'h001F0000 | 32'(m[0]) << 6 | 32'(m));
      gq.push_back({m[0], 3'(m), first[m]});
      gq.push_back({m[0], 3'(m), first[m] ^ 5'h11});
      go(5'h11);
    end
    gq.push_back({1'b0, 3'h2, 5'h04});
    want <= 5'h04;
    @(posedge pclk);
    want <= 5'h00;
    wr(`BMC_OFS_CONFIG, 32'h001F0000);
    go(5'h00);
    gq.push_back({1'b0, 3'h0, 5'h04});
    go(5'h04);
    end_sim();
  end
endmodule // tb_bus_matrix_config
